// *** bench/pci_bus_agent.sv ***
`timescale 1ns/1ps
module pci_bus_agent (
   input  wire logic i_pin_n,
   input  wire logic i_pin_oe,
   output wire logic o_wire_n);
   // pull-up: a released line reads high, never a stale low
   assign o_wire_n = i_pin_oe ? i_pin_n : 1'b1;
endmodule // pci_bus_agent

// *** bench/uncorr_err_report_asserts.sv ***
`timescale 1ns/1ps
module uncorr_err_report_asserts (
   input wire logic        i_clock,
   input wire logic        i_rst,
   input wire logic        i_secondary_parity_response_enable,
   input wire logic        i_system_error_enable,
   input wire logic        i_pcie_imm_data_err,
   input wire logic        i_pci_posted_data_err,
   input wire logic        i_addr_err,
   input wire logic        i_err_msg_sent,
   input wire logic [11:0] i_flag_clear,
   input wire logic        o_bus_parity_error_pin_n,
   input wire logic        o_bus_parity_error_pin_oe,
   input wire logic        o_pri_system_error_flag,
   input wire logic        o_target_abort_signaled);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   wire req = i_secondary_parity_response_enable &
              (i_pcie_imm_data_err | i_pci_posted_data_err);
   wire msg = i_err_msg_sent & i_system_error_enable;
   wire pn = o_bus_parity_error_pin_n, oe = o_bus_parity_error_pin_oe;
   wire ta = o_target_abort_signaled, pri = o_pri_system_error_flag;
   AST_PIN_DRIVE: assert property (req |=> !pn && oe)
      else $error("pin not driven");
   AST_PIN_RESTORE: assert property (!pn && !req |=> pn && oe)
      else $error("pin not restored");
   AST_PIN_RELEASE: assert property (pn && oe && !req |=> !oe)
      else $error("pin not released");
   AST_PIN_QUIET: assert property (!oe && !req |=> !oe)
      else $error("pin driven unasked");
   AST_ADDR_FLAG: assert property (i_addr_err |=> ta)
      else $error("target abort flag not set");
   AST_TA_HOLD: assert property (ta && !i_flag_clear[7] |=> ta)
      else $error("target abort flag lost");
   AST_SYS_SET: assert property (msg |=> pri)
      else $error("system error flag not set");
   AST_SYS_GATE: assert property ($rose(pri) |-> $past(msg))
      else $error("system error flag set unasked");
   cover property (req ##1 !pn ##1 pn ##1 !oe);
   cover property (i_addr_err ##1 ta);
   cover property (req ##1 req ##1 !pn);
   cover property (msg ##1 pri);
endmodule // uncorr_err_report_asserts
bind uncorr_err_report uncorr_err_report_asserts chk_i (.*);

// *** bench/uncorr_err_report_tb.sv ***
`timescale 1ns/1ps
module uncorr_err_report_tb;
   logic        clk = 1'b0, rst = 1'b1, en = 1'b0, fat = 1'b0, msg = 1'b0;
   logic [7:0]  ev = 8'h00;
   logic [11:0] clr = 12'h000;
   wire  [11:0] f;
   wire         pn, oe, pw;
   int          fail_count = 0, total_checks = 0;
   // flags per event, fatal severity, parity response on
   logic [11:0] base [8] = '{12'h125, 12'h224, 12'h220, 12'h440,
                             12'h114, 12'h134, 12'h204, 12'h890};
   initial forever #4 clk = ~clk;
   uncorr_err_report uncorr_err_report_i (
      .i_clock(clk), .i_rst(rst), .i_err_is_fatal(fat), .i_err_msg_sent(msg),
      .i_secondary_parity_response_enable(en), .i_system_error_enable(en),
      .i_pcie_imm_data_err(ev[0]), .i_perr_nonposted_fwd(ev[1]),
      .i_perr_posted_fwd(ev[2]), .i_serr_fwd(ev[3]), .i_addr_err(ev[7]),
      .i_pci_nonposted_data_err(ev[4]), .i_pci_posted_data_err(ev[5]),
      .i_delayed_read_data_err(ev[6]), .i_flag_clear(clr),
      .i_bus_parity_error_pin_n(pw), .o_bus_parity_error_pin_n(pn),
      .o_bus_parity_error_pin_oe(oe), .o_pri_detected_parity_flag(f[0]),
      .o_pri_system_error_flag(f[1]), .o_fatal_error_detected(f[2]),
      .o_nonfatal_error_detected(f[3]), .o_sec_detected_parity_flag(f[4]),
      .o_master_parity_error_flag(f[5]), .o_sec_system_error_flag(f[6]),
      .o_target_abort_signaled(f[7]), .o_sec_parity_report_seen(f[9]),
      .o_sec_uncorrectable_data_error(f[8]), .o_sec_system_error_seen(f[10]),
      .o_sec_uncorrectable_address_error(f[11]));
   pci_bus_agent pci_bus_agent_i (
      .i_pin_n(pn), .i_pin_oe(oe), .o_wire_n(pw));
   task automatic cmp(input logic [11:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test(input int late);
      fail_count += late;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic clear_all();
      @(posedge clk) clr <= 12'hFFF;
      @(posedge clk) clr <= 12'h000;
      #1 cmp(f, 12'h000);
   endtask
   task automatic test_events(input logic sev, input logic par);
      logic [11:0] e;
      logic        drv;
      for (int k = 0; k < 8; k++) begin
         e = base[k] | {10'h000, par, 1'b0};
         if (!sev && e[2]) e = e ^ 12'h00C;
         if (!par) e[5] = 1'b0;
         drv = par && (k == 0 || k == 5);
         @(posedge clk) {fat, en, msg, ev} <= {sev, par, 1'b1, 8'h01 << k};
         @(posedge clk) {msg, ev} <= 9'h000;
         #1 cmp(f, e);
         cmp({10'h000, pw, oe}, {10'h000, !drv, drv});
         @(posedge clk) #1 cmp({10'h000, pw, oe}, {10'h000, 1'b1, drv});
         @(posedge clk) #1 cmp({10'h000, pw, oe}, 12'h002);
         clear_all();
      end
      $display("event table done, fatal %b enable %b", sev, par);
   endtask
   task automatic test_sticky();
      @(posedge clk) ev <= 8'h80;
      @(posedge clk) clr <= 12'h010;
      @(posedge clk) {ev, clr} <= {8'h00, 12'h080};
      @(posedge clk) clr <= 12'h000;
      #1 cmp(f, 12'h810);
      clear_all();
      $display("sticky flags done");
   endtask
   task automatic test_perr_burst();
      // two requests back to back, then one landing in the restore cycle
      logic [7:0] seq [6] = '{8'h01, 8'h20, 8'h00, 8'h01, 8'h00, 8'h00};
      logic [1:0] pin [6] = '{2'b01, 2'b01, 2'b11, 2'b01, 2'b11, 2'b10};
      @(posedge clk) {fat, en, msg} <= 3'b010;
      for (int k = 0; k < 6; k++) begin
         @(posedge clk) ev <= seq[k];
         if (k > 0) #1 cmp({10'h000, pw, oe}, {10'h000, pin[k-1]});
      end
      @(posedge clk) #1 cmp({10'h000, pw, oe}, {10'h000, pin[5]});
      cmp(f, 12'h139);
      clear_all();
      $display("parity pin burst done");
   endtask
   task automatic test_reset();
      // reset in mid-run with flags set and the pin being driven
      @(posedge clk) {fat, en, ev} <= {2'b01, 8'h81};
      @(posedge clk) {ev, rst} <= {8'h00, 1'b1};
      #1 cmp(f, 12'h9B9);
      cmp({10'h000, pw, oe}, 12'h001);
      @(posedge clk) #1 cmp(f, 12'h000);
      cmp({10'h000, pw, oe}, 12'h002);
      @(posedge clk) rst <= 1'b0;
      @(posedge clk) ev <= 8'h80;
      #1 cmp(f, 12'h000);
      @(posedge clk) ev <= 8'h00;
      #1 cmp(f, 12'h890);
      clear_all();
      $display("mid-run reset done");
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      test_events(1'b1, 1'b1);
      test_events(1'b0, 1'b0);
      test_sticky();
      test_perr_burst();
      test_reset();
      end_of_test(0);
   end
   initial #20000 end_of_test(1);
endmodule // uncorr_err_report_tb

// *** rtl/sticky_flag_bank.sv ***
`timescale 1ns/1ps
module sticky_flag_bank #(
   parameter int unsigned WIDTH = uncorr_err_pkg::NUM_FLAGS
) (
   // clock and reset
   input  wire logic             i_clock,
   input  wire logic             i_rst,
   // set and clear strobes
   input  wire logic [WIDTH-1:0] i_set,
   input  wire logic [WIDTH-1:0] i_clear,
   // held flags
   output logic      [WIDTH-1:0] o_flags
);

   logic [WIDTH-1:0] flags_r;
   logic [WIDTH-1:0] flags_nxt;

   // ==========================================================
   // per-bit sticky logic
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_flag
         // a set in the clearing cycle wins so no event is lost
         always_comb begin
            flags_nxt[g] = (flags_r[g] & ~i_clear[g]) | i_set[g];
         end
      end
   endgenerate

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         flags_r <= uncorr_err_pkg::FLAGS_RESET;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   assign o_flags = flags_r;

endmodule // sticky_flag_bank

// *** rtl/uncorr_err_pkg.sv ***
package uncorr_err_pkg;

   // ==========================================================
   // sticky flag positions in the flag vector
   localparam int unsigned NUM_FLAGS          = 12;
   localparam int unsigned PRI_DETECTED_PAR   = 0;
   localparam int unsigned PRI_SYSTEM_ERR     = 1;
   localparam int unsigned FATAL_DETECTED     = 2;
   localparam int unsigned NONFATAL_DETECTED  = 3;
   localparam int unsigned SEC_DETECTED_PAR   = 4;
   localparam int unsigned SEC_MASTER_PAR     = 5;
   localparam int unsigned SEC_SYSTEM_ERR     = 6;
   localparam int unsigned SEC_TARGET_ABORT   = 7;
   localparam int unsigned SEC_UNCORR_DATA    = 8;
   localparam int unsigned SEC_PAR_REPORT     = 9;
   localparam int unsigned SEC_SYSERR_SEEN    = 10;
   localparam int unsigned SEC_UNCORR_ADDR    = 11;

   // ==========================================================
   // reset values
   localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 12'h000;

   // ==========================================================
   // parity-error pin driver states
   typedef enum logic [2:0] {
      PERR_IDLE    = 3'b001,
      PERR_ASSERT  = 3'b010,
      PERR_RESTORE = 3'b100
   } perr_state_t;

endpackage

// *** rtl/uncorr_err_report.sv ***
// What this block does
// - pcie-side immediate data error sets parity, severity and data-error flags
// - that error drives parity pin and master parity flag if response enabled
// - primary system error flag needs error message sent and enable set
// - parity pin on non-posted forward sets severity, report seen, maybe master
// - parity pin on posted forward sets report seen, maybe master flag
// - system error pin seen sets secondary system error and seen flags
// - pci non-posted write data error sets severity, parity, data-error flags
// - pci posted write data error drives parity pin only if enabled
// - pci posted write data error sets severity, parity, data, maybe master
// - delayed read completion data error sets severity and report seen
// - address error sets parity, target abort and address-error flags
`timescale 1ns/1ps
module uncorr_err_report (
   // clock and reset
   input  wire logic                  i_clock,
   input  wire logic                  i_rst,
   // configuration
   input  wire logic                  i_secondary_parity_response_enable,
   input  wire logic                  i_system_error_enable,
   // error events, one-cycle pulses
   input  wire logic                  i_pcie_imm_data_err,
   input  wire logic                  i_perr_nonposted_fwd,
   input  wire logic                  i_perr_posted_fwd,
   input  wire logic                  i_serr_fwd,
   input  wire logic                  i_pci_nonposted_data_err,
   input  wire logic                  i_pci_posted_data_err,
   input  wire logic                  i_delayed_read_data_err,
   input  wire logic                  i_addr_err,
   input  wire logic                  i_err_is_fatal,
   input  wire logic                  i_err_msg_sent,
   // software write-one-to-clear strobes, one bit per flag
   input  wire logic [11:0]           i_flag_clear,
   // parity error pin, active low
   input  wire logic                  i_bus_parity_error_pin_n,
   output logic                       o_bus_parity_error_pin_n,
   output logic                       o_bus_parity_error_pin_oe,
   // status flags
   output logic                       o_pri_detected_parity_flag,
   output logic                       o_pri_system_error_flag,
   output logic                       o_fatal_error_detected,
   output logic                       o_nonfatal_error_detected,
   output logic                       o_sec_detected_parity_flag,
   output logic                       o_master_parity_error_flag,
   output logic                       o_sec_system_error_flag,
   output logic                       o_target_abort_signaled,
   output logic                       o_sec_uncorrectable_data_error,
   output logic                       o_sec_parity_report_seen,
   output logic                       o_sec_system_error_seen,
   output logic                       o_sec_uncorrectable_address_error
);

   // one bit per status flag, in the order of the clear strobes
   localparam int unsigned NF = uncorr_err_pkg::NUM_FLAGS;

   // flag decode
   logic [NF-1:0]               flag_set;
   logic [NF-1:0]               flags;
   logic                        sev_event;
   logic                        uncorr_data_event;
   logic                        master_par_event;
   logic                        par_report_event;
   logic                        sec_par_event;
   // parity pin driver
   logic                        perr_request;
   uncorr_err_pkg::perr_state_t perr_state_r;
   uncorr_err_pkg::perr_state_t perr_state_nxt;
   logic                        perr_n_r;
   logic                        perr_n_nxt;
   logic                        perr_oe_r;
   logic                        perr_oe_nxt;

   // ==========================================================
   // event decode into flag set strobes
   always_comb begin
      flag_set = '0;
      // events that count towards pcie device severity
      sev_event = i_pcie_imm_data_err
                | i_perr_nonposted_fwd
                | i_pci_nonposted_data_err
                | i_pci_posted_data_err
                | i_delayed_read_data_err;
      // an address error is left out of severity; it is reported through
      // the secondary flags and, if a message went out, the system flag
      // data errors kept in the secondary data-error record
      uncorr_data_event = i_pcie_imm_data_err
                        | i_pci_nonposted_data_err
                        | i_pci_posted_data_err;
      // parity trouble seen or caused by the bridge as bus master
      master_par_event  = i_pcie_imm_data_err
                        | i_perr_nonposted_fwd
                        | i_perr_posted_fwd
                        | i_pci_posted_data_err;
      // parity reported by the far agent, and bad delayed read data
      par_report_event  = i_perr_nonposted_fwd
                        | i_perr_posted_fwd
                        | i_delayed_read_data_err;
      // bad parity caught by the bridge as secondary target
      sec_par_event     = i_pci_nonposted_data_err
                        | i_pci_posted_data_err
                        | i_addr_err;
      // severity is the level that arrives with the event pulse
      flag_set[uncorr_err_pkg::FATAL_DETECTED]    = sev_event & i_err_is_fatal;
      flag_set[uncorr_err_pkg::NONFATAL_DETECTED] = sev_event &
                                                    ~i_err_is_fatal;
      flag_set[uncorr_err_pkg::PRI_DETECTED_PAR]  = i_pcie_imm_data_err;
      flag_set[uncorr_err_pkg::SEC_UNCORR_DATA]   = uncorr_data_event;
      flag_set[uncorr_err_pkg::SEC_MASTER_PAR]    =
         i_secondary_parity_response_enable & master_par_event;
      flag_set[uncorr_err_pkg::SEC_PAR_REPORT]    = par_report_event;
      flag_set[uncorr_err_pkg::SEC_SYSTEM_ERR]    = i_serr_fwd;
      flag_set[uncorr_err_pkg::SEC_SYSERR_SEEN]   = i_serr_fwd;
      flag_set[uncorr_err_pkg::SEC_DETECTED_PAR]  = sec_par_event;
      flag_set[uncorr_err_pkg::SEC_TARGET_ABORT]  = i_addr_err;
      flag_set[uncorr_err_pkg::SEC_UNCORR_ADDR]   = i_addr_err;
      // the message itself is built elsewhere; only its sending is seen
      flag_set[uncorr_err_pkg::PRI_SYSTEM_ERR] = i_err_msg_sent &
                                                 i_system_error_enable;
   end

   // ==========================================================
   // sticky flags
   // a new event in the clearing cycle wins inside the bank, so
   // software never wipes out a report it has not yet read
   sticky_flag_bank #(
      .WIDTH (NF)
   ) u_flags (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .i_set   (flag_set),
      .i_clear (i_flag_clear),
      .o_flags (flags)
   );

   // ==========================================================
   // parity error pin driver
   // one cycle low, then one cycle driven high before release so the
   // shared pull-up line is not left to float up slowly
   assign perr_request = i_secondary_parity_response_enable &
                         (i_pcie_imm_data_err
                          | i_pci_posted_data_err);

   always_comb begin
      perr_state_nxt = perr_state_r;
      perr_n_nxt     = 1'b1;
      perr_oe_nxt    = 1'b0;
      case (perr_state_r)
         uncorr_err_pkg::PERR_IDLE: begin
            if (perr_request) begin
               perr_state_nxt = uncorr_err_pkg::PERR_ASSERT;
               perr_n_nxt     = 1'b0;
               perr_oe_nxt    = 1'b1;
            end
         end
         uncorr_err_pkg::PERR_ASSERT: begin
            // a request here extends the low phase by one cycle
            if (perr_request) begin
               perr_n_nxt  = 1'b0;
            end else begin
               perr_state_nxt = uncorr_err_pkg::PERR_RESTORE;
            end
            perr_oe_nxt = 1'b1;
         end
         uncorr_err_pkg::PERR_RESTORE: begin
            // a request here pulls the line low again at once
            if (perr_request) begin
               perr_state_nxt = uncorr_err_pkg::PERR_ASSERT;
               perr_n_nxt     = 1'b0;
               perr_oe_nxt    = 1'b1;
            end else begin
               perr_state_nxt = uncorr_err_pkg::PERR_IDLE;
            end
         end
         default: begin
            // a stray code falls back to idle with the pin released
            perr_state_nxt = uncorr_err_pkg::PERR_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         perr_state_r <= uncorr_err_pkg::PERR_IDLE;
         perr_n_r     <= 1'b1;
         perr_oe_r    <= 1'b0;
      end else begin
         perr_state_r <= perr_state_nxt;
         perr_n_r     <= perr_n_nxt;
         perr_oe_r    <= perr_oe_nxt;
      end
   end

   // ==========================================================
   // outputs, all from flip-flops
   // the flags are the bank's own registers, passed through unchanged
   assign o_bus_parity_error_pin_n  = perr_n_r;
   assign o_bus_parity_error_pin_oe = perr_oe_r;
   assign o_pri_detected_parity_flag =
      flags[uncorr_err_pkg::PRI_DETECTED_PAR];
   assign o_pri_system_error_flag    = flags[uncorr_err_pkg::PRI_SYSTEM_ERR];
   assign o_fatal_error_detected     = flags[uncorr_err_pkg::FATAL_DETECTED];
   assign o_nonfatal_error_detected  =
      flags[uncorr_err_pkg::NONFATAL_DETECTED];
   assign o_sec_detected_parity_flag =
      flags[uncorr_err_pkg::SEC_DETECTED_PAR];
   assign o_master_parity_error_flag = flags[uncorr_err_pkg::SEC_MASTER_PAR];
   assign o_sec_system_error_flag    = flags[uncorr_err_pkg::SEC_SYSTEM_ERR];
   assign o_target_abort_signaled    =
      flags[uncorr_err_pkg::SEC_TARGET_ABORT];
   assign o_sec_uncorrectable_data_error =
      flags[uncorr_err_pkg::SEC_UNCORR_DATA];
   assign o_sec_parity_report_seen   = flags[uncorr_err_pkg::SEC_PAR_REPORT];
   assign o_sec_system_error_seen    = flags[uncorr_err_pkg::SEC_SYSERR_SEEN];
   assign o_sec_uncorrectable_address_error =
      flags[uncorr_err_pkg::SEC_UNCORR_ADDR];

   // the pin's own level is only looked at by the bus logic that
   // produces the forwarding events; kept here for a uniform pin bundle
   logic unused_pin;
   assign unused_pin = i_bus_parity_error_pin_n;

endmodule // uncorr_err_report
